/* rtl/serial_pin_pkg.sv */
package serial_pin_pkg;

  // Register offsets
  localparam logic [15:0] pin_control_offset  = 16'h105e;
  localparam logic [15:0] priority_offset     = 16'h105f;

  // Pin control field positions
  localparam int rx_dir_bit      = 0;
  localparam int rx_func_bit     = 1;
  localparam int rx_out_bit      = 2;
  localparam int rx_in_bit       = 3;
  localparam int tx_dir_bit      = 4;
  localparam int tx_func_bit     = 5;
  localparam int tx_out_bit      = 6;
  localparam int tx_in_bit       = 7;

  // Priority field positions
  localparam int suspend_en_bit  = 4;
  localparam int rx_prio_bit     = 5;
  localparam int tx_prio_bit     = 6;
  localparam int self_test_bit   = 7;

  // Reset values
  localparam logic [7:0] pin_control_reset = 8'h00;
  localparam logic [3:0] priority_reset    = 4'h0;
  localparam logic [3:0] reserved_read     = 4'h0;

  // Per-pin general-purpose settings
  typedef struct packed {
    logic function_select;
    logic direction;
    logic output_value;
  } pin_setting_type;

  // Pad signals, enable active low
  typedef struct packed {
    logic drive;
    logic drive_enable_n;
  } pad_drive_type;

endpackage

/* rtl/serial_pin_sync.sv */
`timescale 1ns/1ps
// Three-stage pin sampler; level changes once stages two and three agree
module serial_pin_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pin level
  input  wire logic pin_in,
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end

endmodule // serial_pin_sync

/* rtl/serial_pin_mux.sv */
`timescale 1ns/1ps
// Selects the pad driver for one pin
module serial_pin_mux (
  // Settings
  input  wire serial_pin_pkg::pin_setting_type setting,
  // Serial side
  input  wire logic                            serial_drive,
  input  wire logic                            serial_drive_enable_n,
  // Pad
  output serial_pin_pkg::pad_drive_type        pad
);

  always_comb begin
    if (setting.function_select) begin
      pad.drive          = serial_drive;
      pad.drive_enable_n = serial_drive_enable_n;
    end else begin
      pad.drive          = setting.output_value;
      pad.drive_enable_n = ~setting.direction;
    end
  end

endmodule // serial_pin_mux

/* rtl/serial_pin_and_priority_control.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE1: Transmit function bit 5: 0 general I/O, 1 serial transmitter output.
// RULE2: Transmit direction bit 4 in I/O mode: 0 input, 1 output.
// RULE3: Transmit output bit 6 drives pin only in I/O mode as output.
// RULE4: Transmit input bit 7 reads live pin level in every mode.
// RULE5: Receive output bit 2 drives pin only in I/O mode as output.
// RULE6: Receive input bit 3 reads live receive pin level.
// RULE7: Priority register always readable; writes only in privileged mode.
// RULE8: Upper four priority bits reset to zero.
// RULE9: Priority bits 0 to 3 reserved; reads return zero here.
// RULE10: Suspend enable bit 4 matters only while emulator suspends.
// RULE11: Suspend: enable 0 finishes current sequence then stops; 1 freezes at once.
// RULE12: Receiver priority bit 5: 0 level 1, 1 level 2.
// RULE13: Transmitter priority bit 6: 0 level 1, 1 level 2.
// RULE14: Receive function bit 1: 0 general I/O, 1 serial receiver input.
// RULE15: Receive direction bit 0 in I/O mode: 0 input, 1 output.
// RULE16: Self-test bit 7 is a privileged stored bit without serial effect.
// RULE17: In serial function the I/O direction and data settings are ignored.
module serial_pin_and_priority_control (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Processor state
  input  wire logic        privileged_mode,
  input  wire logic        emulator_suspend,
  // Serial unit side
  input  wire logic        serial_tx_data,
  input  wire logic        serial_sequence_busy,
  output logic             serial_rx_data,
  output logic             serial_run_enable,
  output logic             receive_irq_priority,
  output logic             transmit_irq_priority,
  output logic             serial_self_test_bit,
  // Transmit pin
  input  wire logic        serial_tx_pin_in,
  output logic             serial_tx_pin_out,
  output logic             serial_tx_pin_oe_n,
  // Receive pin
  input  wire logic        serial_rx_pin_in,
  output logic             serial_rx_pin_out,
  output logic             serial_rx_pin_oe_n
);

  // Stored writable bits of the pin control register
  logic                            rx_pin_direction;
  logic                            rx_pin_function_select;
  logic                            rx_pin_output_value;
  logic                            tx_pin_direction;
  logic                            tx_pin_function_select;
  logic                            tx_pin_output_value;
  // Priority register bits
  logic                            emulation_suspend_enable;
  logic                            receive_prio;
  logic                            transmit_prio;
  logic                            self_test;
  // Live pin levels
  logic                            tx_pin_input_value;
  logic                            rx_pin_input_value;
  // Suspend control
  logic                            suspended;
  logic                            next_suspended;
  logic [7:0]                      next_rdata;
  serial_pin_pkg::pin_setting_type tx_setting;
  serial_pin_pkg::pin_setting_type rx_setting;
  serial_pin_pkg::pad_drive_type   tx_pad;
  serial_pin_pkg::pad_drive_type   rx_pad;

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] offset);
    hit = (addr == offset);
  endfunction

  // Pin control register writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_pin_direction       <= serial_pin_pkg::pin_control_reset[serial_pin_pkg::rx_dir_bit];
      rx_pin_function_select <= serial_pin_pkg::pin_control_reset[serial_pin_pkg::rx_func_bit];
      rx_pin_output_value    <= serial_pin_pkg::pin_control_reset[serial_pin_pkg::rx_out_bit];
      tx_pin_direction       <= serial_pin_pkg::pin_control_reset[serial_pin_pkg::tx_dir_bit];
      tx_pin_function_select <= serial_pin_pkg::pin_control_reset[serial_pin_pkg::tx_func_bit];
      tx_pin_output_value    <= serial_pin_pkg::pin_control_reset[serial_pin_pkg::tx_out_bit];
    end else if (reg_write && hit(reg_addr, serial_pin_pkg::pin_control_offset)) begin
      rx_pin_direction       <= reg_wdata[serial_pin_pkg::rx_dir_bit];   // [RULE15]
      rx_pin_function_select <= reg_wdata[serial_pin_pkg::rx_func_bit];  // [RULE14]
      rx_pin_output_value    <= reg_wdata[serial_pin_pkg::rx_out_bit];   // [RULE5]
      tx_pin_direction       <= reg_wdata[serial_pin_pkg::tx_dir_bit];   // [RULE2]
      tx_pin_function_select <= reg_wdata[serial_pin_pkg::tx_func_bit];  // [RULE1]
      tx_pin_output_value    <= reg_wdata[serial_pin_pkg::tx_out_bit];   // [RULE3]
    end
  end

  // Priority register; unprivileged writes dropped silently
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      emulation_suspend_enable <= serial_pin_pkg::priority_reset[0];  // [RULE8]
      receive_prio             <= serial_pin_pkg::priority_reset[1];
      transmit_prio            <= serial_pin_pkg::priority_reset[2];
      self_test                <= serial_pin_pkg::priority_reset[3];
    end else if (reg_write && privileged_mode && hit(reg_addr, serial_pin_pkg::priority_offset)) begin  // [RULE7]
      emulation_suspend_enable <= reg_wdata[serial_pin_pkg::suspend_en_bit];
      receive_prio             <= reg_wdata[serial_pin_pkg::rx_prio_bit];
      transmit_prio            <= reg_wdata[serial_pin_pkg::tx_prio_bit];
      self_test                <= reg_wdata[serial_pin_pkg::self_test_bit];  // [RULE16]
    end
  end

  // Pin level sampling; pins are asynchronous to sys_clk
  serial_pin_sync tx_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (serial_tx_pin_in),
    .level   (tx_pin_input_value)
  );

  serial_pin_sync rx_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (serial_rx_pin_in),
    .level   (rx_pin_input_value)
  );

  // Pad selection
  assign tx_setting = '{function_select: tx_pin_function_select,
                        direction:       tx_pin_direction,
                        output_value:    tx_pin_output_value};
  assign rx_setting = '{function_select: rx_pin_function_select,
                        direction:       rx_pin_direction,
                        output_value:    rx_pin_output_value};

  // Transmitter always drives the pin in serial mode
  serial_pin_mux tx_mux (
    .setting               (tx_setting),
    .serial_drive          (serial_tx_data),
    .serial_drive_enable_n (1'b0),
    .pad                   (tx_pad)
  );  // [RULE1] [RULE17]

  // Receiver pin is never driven in serial mode
  serial_pin_mux rx_mux (
    .setting               (rx_setting),
    .serial_drive          (1'b0),
    .serial_drive_enable_n (1'b1),
    .pad                   (rx_pad)
  );  // [RULE14] [RULE17]

  assign serial_tx_pin_out  = tx_pad.drive;           // [RULE3]
  assign serial_tx_pin_oe_n = tx_pad.drive_enable_n;  // [RULE2]
  assign serial_rx_pin_out  = rx_pad.drive;           // [RULE5]
  assign serial_rx_pin_oe_n = rx_pad.drive_enable_n;  // [RULE15]

  // Receiver sees idle high while the pin is general-purpose
  assign serial_rx_data = rx_pin_function_select ? rx_pin_input_value : 1'b1;  // [RULE14]

  // Emulator suspend handling
  always_comb begin
    next_suspended = 1'b0;
    if (emulator_suspend) begin  // [RULE10]
      if (emulation_suspend_enable) begin
        next_suspended = 1'b1;  // [RULE11]
      end else begin
        next_suspended = suspended || !serial_sequence_busy;  // [RULE11]
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      suspended <= 1'b0;
    end else begin
      suspended <= next_suspended;
    end
  end

  // Freeze takes effect in the same cycle as the suspend request
  assign serial_run_enable = !(emulator_suspend && emulation_suspend_enable) && !suspended;  // [RULE11]

  assign receive_irq_priority  = receive_prio;   // [RULE12]
  assign transmit_irq_priority = transmit_prio;  // [RULE13]
  assign serial_self_test_bit  = self_test;      // [RULE16]

  // Read path, data one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (hit(reg_addr, serial_pin_pkg::pin_control_offset)) begin
      next_rdata[serial_pin_pkg::rx_dir_bit]  = rx_pin_direction;
      next_rdata[serial_pin_pkg::rx_func_bit] = rx_pin_function_select;
      next_rdata[serial_pin_pkg::rx_out_bit]  = rx_pin_output_value;
      next_rdata[serial_pin_pkg::rx_in_bit]   = rx_pin_input_value;  // [RULE6]
      next_rdata[serial_pin_pkg::tx_dir_bit]  = tx_pin_direction;
      next_rdata[serial_pin_pkg::tx_func_bit] = tx_pin_function_select;
      next_rdata[serial_pin_pkg::tx_out_bit]  = tx_pin_output_value;
      next_rdata[serial_pin_pkg::tx_in_bit]   = tx_pin_input_value;  // [RULE4]
    end else if (hit(reg_addr, serial_pin_pkg::priority_offset)) begin
      next_rdata = {self_test, transmit_prio, receive_prio, emulation_suspend_enable,
                    serial_pin_pkg::reserved_read};  // [RULE7] [RULE9]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // serial_pin_and_priority_control

/* verif/serial_pin_properties.sv */
`timescale 1ns/1ps
module serial_pin_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  // Processor and serial side
  input wire logic        privileged_mode,
  input wire logic        emulator_suspend,
  input wire logic        serial_tx_data,
  input wire logic        serial_sequence_busy,
  input wire logic        serial_run_enable,
  input wire logic        receive_irq_priority,
  input wire logic        transmit_irq_priority,
  input wire logic        serial_self_test_bit,
  // Pins
  input wire logic        serial_tx_pin_out,
  input wire logic        serial_tx_pin_oe_n,
  input wire logic        serial_rx_pin_out,
  input wire logic        serial_rx_pin_oe_n
);
  logic [7:0] pc;
  logic [3:0] pr;
  // Shadow copies of both registers, built from bus traffic only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc <= 8'h00;
      pr <= 4'h0;
    end else if (reg_write) begin
      if (reg_addr == serial_pin_pkg::pin_control_offset) pc <= reg_wdata;
      if (privileged_mode && reg_addr == serial_pin_pkg::priority_offset) pr <= reg_wdata[7:4];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_tx_serial; pc[5] |-> !serial_tx_pin_oe_n && serial_tx_pin_out == serial_tx_data; endproperty
  a_tx_serial: assert property (p_tx_serial) else $error("tx pin not serial");
  property p_tx_gpio; !pc[5] |-> serial_tx_pin_oe_n == !pc[4] && (!pc[4] || serial_tx_pin_out == pc[6]); endproperty
  a_tx_gpio: assert property (p_tx_gpio) else $error("tx pin gpio drive wrong");
  property p_rx_serial; pc[1] |-> serial_rx_pin_oe_n; endproperty
  a_rx_serial: assert property (p_rx_serial) else $error("rx pin driven in serial mode");
  property p_rx_gpio; !pc[1] |-> serial_rx_pin_oe_n == !pc[0] && (!pc[0] || serial_rx_pin_out == pc[2]); endproperty
  a_rx_gpio: assert property (p_rx_gpio) else $error("rx pin gpio drive wrong");
  property p_prio; {serial_self_test_bit, transmit_irq_priority, receive_irq_priority} == pr[3:1]; endproperty
  a_prio: assert property (p_prio) else $error("priority outputs wrong");
  property p_rd_prio;
    reg_read && reg_addr == serial_pin_pkg::priority_offset |=> reg_rdata == {$past(pr), 4'h0};
  endproperty
  a_rd_prio: assert property (p_rd_prio) else $error("priority read wrong");
  property p_freeze; pr[0] && emulator_suspend |-> !serial_run_enable; endproperty
  a_freeze: assert property (p_freeze) else $error("no freeze");
  property p_finish; emulator_suspend && !pr[0] && !serial_sequence_busy |=> !serial_run_enable || !emulator_suspend;
  endproperty
  a_finish: assert property (p_finish) else $error("no stop after sequence");
  property p_run_free; !emulator_suspend && !$past(emulator_suspend) |-> serial_run_enable; endproperty
  a_run_free: assert property (p_run_free) else $error("stopped without suspend");
  c_serial: cover property (pc[5] && pc[1]);
  c_freeze: cover property (pr[0] && emulator_suspend);
  c_finish: cover property (emulator_suspend && !pr[0] && !serial_sequence_busy);
endmodule // serial_pin_checker

/* verif/serial_pin_far_end.sv */
`timescale 1ns/1ps
// Board side of one pin; weak pull-up when nobody drives, device wins a clash
module serial_pin_far_end (
  // Device pad
  input  wire logic drive,
  input  wire logic drive_enable_n,
  // Board driver
  input  wire logic ext_enable,
  input  wire logic ext_value,
  // Wire level
  output logic      level
);
  assign level = !drive_enable_n ? drive : (ext_enable ? ext_value : 1'b1);
endmodule // serial_pin_far_end

/* verif/serial_pin_and_priority_control_tb.sv */
`timescale 1ns/1ps
module serial_pin_and_priority_control_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0, reg_read = 1'b0, privileged_mode = 1'b0, emulator_suspend = 1'b0;
  logic        serial_tx_data = 1'b0, serial_sequence_busy = 1'b0;
  logic [7:0]  reg_rdata;
  logic        serial_rx_data, serial_run_enable, receive_irq_priority, transmit_irq_priority;
  logic        serial_self_test_bit, serial_tx_pin_in, serial_tx_pin_out, serial_tx_pin_oe_n;
  logic        serial_rx_pin_in, serial_rx_pin_out, serial_rx_pin_oe_n;
  logic [1:0]  ext_en = 2'b00, ext_val = 2'b00;
  int          err_total = 0, check_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  serial_pin_and_priority_control dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .privileged_mode, .emulator_suspend, .serial_tx_data, .serial_sequence_busy, .serial_rx_data,
    .serial_run_enable, .receive_irq_priority, .transmit_irq_priority, .serial_self_test_bit,
    .serial_tx_pin_in, .serial_tx_pin_out, .serial_tx_pin_oe_n, .serial_rx_pin_in, .serial_rx_pin_out,
    .serial_rx_pin_oe_n);
  serial_pin_far_end tx_end (.drive(serial_tx_pin_out), .drive_enable_n(serial_tx_pin_oe_n),
    .ext_enable(ext_en[1]), .ext_value(ext_val[1]), .level(serial_tx_pin_in));
  serial_pin_far_end rx_end (.drive(serial_rx_pin_out), .drive_enable_n(serial_rx_pin_oe_n),
    .ext_enable(ext_en[0]), .ext_value(ext_val[0]), .level(serial_rx_pin_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Pin levels need about four edges through the sampler
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #5000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    settle(5);
    rd_chk(16'h105e, 8'h88);
    rd_chk(16'h105f, 8'h00);
    wr(16'h1060, 8'hff);
    rd_chk(16'h1060, 8'h00);
    $display("test reset done");
    wr(16'h105e, 8'h55);
    settle(5);
    chk({6'h00, serial_tx_pin_oe_n, serial_rx_pin_oe_n}, 8'h00);
    rd_chk(16'h105e, 8'hdd);
    wr(16'h105e, 8'h11);
    settle(5);
    rd_chk(16'h105e, 8'h11);
    @(posedge sys_clk);
    ext_en <= 2'b11;
    ext_val <= 2'b10;
    wr(16'h105e, 8'h00);
    settle(5);
    rd_chk(16'h105e, 8'h80);
    chk({7'h00, serial_rx_data}, 8'h01);
    $display("test gpio done");
    @(posedge sys_clk);
    ext_en <= 2'b01;
    // Serial level opposite to the stored output bit, so a leaking I/O drive shows
    serial_tx_data <= 1'b0;
    wr(16'h105e, 8'h77);
    settle(5);
    rd_chk(16'h105e, 8'h77);
    chk({6'h00, serial_rx_pin_oe_n, serial_rx_data}, 8'h02);
    $display("test serial done");
    wr(16'h105f, 8'hf0);
    rd_chk(16'h105f, 8'h00);
    @(posedge sys_clk);
    privileged_mode <= 1'b1;
    wr(16'h105f, 8'hff);
    rd_chk(16'h105f, 8'hf0);
    chk({5'h00, serial_self_test_bit, transmit_irq_priority, receive_irq_priority}, 8'h07);
    wr(16'h105f, 8'h30);
    settle(2);
    chk({5'h00, serial_self_test_bit, transmit_irq_priority, receive_irq_priority}, 8'h01);
    chk({7'h00, serial_run_enable}, 8'h01);
    $display("test priority done");
    @(posedge sys_clk);
    emulator_suspend <= 1'b1;
    serial_sequence_busy <= 1'b1;
    settle(1);
    chk({7'h00, serial_run_enable}, 8'h00);
    @(posedge sys_clk);
    emulator_suspend <= 1'b0;
    wr(16'h105f, 8'h00);
    @(posedge sys_clk);
    emulator_suspend <= 1'b1;
    settle(3);
    chk({7'h00, serial_run_enable}, 8'h01);
    @(posedge sys_clk);
    serial_sequence_busy <= 1'b0;
    settle(2);
    chk({7'h00, serial_run_enable}, 8'h00);
    $display("test suspend done");
    end_of_test();
  end
endmodule // serial_pin_and_priority_control_tb

bind serial_pin_and_priority_control serial_pin_checker checker_i (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .privileged_mode, .emulator_suspend, .serial_tx_data, .serial_sequence_busy,
  .serial_run_enable, .receive_irq_priority, .transmit_irq_priority, .serial_self_test_bit, .serial_tx_pin_out,
  .serial_tx_pin_oe_n, .serial_rx_pin_out, .serial_rx_pin_oe_n);
